// ### verilog/attitude_packet_framer.v
// Packet framer of an attitude sensor unit: 26-byte packets to a byte serialiser.
// Assumes a UART taking bytes on valid/ready, an APB master, one 100 MHz clock.
//
// Summary of operation
// - Packet opens with bytes AA then 55.
// - Each 16-bit word goes high byte first.
// - Measurements are signed two's complement words.
// - Angles, rates, accelerations follow header in order.
// - Model number, then health word follow accelerations.
// - Checksum word ends packet, high byte first.
// - Checksum is content sum modulo 0xFFFF.
// - Default 100 packets/s; rate rewritable over APB, new period applied at a period boundary.
// - Packets stream continuously from reset, unrequested.
// - Received serial bytes are ignored entirely.
// - Next sample captured while current packet sends.
// - Packet bytes leave over serial port last.
// - Calibration mode marks data as not valid.
// - Over-range is reported inside the packet.
// - Over-range restarts init; 90 s level needed.
// - Health bits 10:9 carry algorithm state.
// - Soft failure past 2100 packets latches hard.
// - Health bit 4 flags serial port errors.
`timescale 1ns/1ns
`default_nettype none
`include "attitude_packet_framer_defines.vh"

module attitude_packet_framer #(
  parameter [35:0] PERIOD_CYCLES = `PERIOD_CYC, // Default sample period
  parameter [35:0] INIT_CYCLES = `INIT_CYC // Level time to full accuracy
) (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // APB slave
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Measurements, roll angle in the top word
  input wire meas_valid,
  input wire [143:0] meas_words,
  // Status from the processing logic
  input wire over_range,
  input wire level_ok,
  input wire gyro_only,
  input wire soft_fail,
  input wire turn_det,
  input wire rx_err,
  // Pins from outside the clock domain
  input wire cal_pin,
  input wire rx_pin,
  // Byte stream to the serialiser
  output reg [7:0] tx_data,
  output reg tx_valid,
  input wire tx_ready
);

  // Algorithm states
  localparam [2:0] A_NRDY = 3'b001;
  localparam [2:0] A_INIT = 3'b010;
  localparam [2:0] A_FULL = 3'b100;

  // Packet states
  localparam [1:0] P_IDLE = 2'b01;
  localparam [1:0] P_SEND = 2'b10;

  // Calibration pin synchroniser
  reg cal_s1; // First stage, read by cal_s2 only
  reg cal_s2; // Safe level

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      cal_s1 <= 1'b0;
      cal_s2 <= 1'b0;
    end else begin
      cal_s1 <= cal_pin;
      cal_s2 <= cal_s1;
    end
  end

  // The receive pin is deliberately left unread: no byte can steer the block
  wire rx_unused = rx_pin;

  // Sample snapshot, refilled while a packet is on the wire
  reg [143:0] snap; // Latest processed sample
  reg seen_sample; // At least one sample arrived

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      snap <= 144'h0;
      seen_sample <= 1'b0;
    end else if (meas_valid) begin
      snap <= meas_words;
      seen_sample <= 1'b1;
    end
  end

  // Register file state
  reg [15:0] model_cfg; // Model configuration word
  reg [31:0] period; // Requested sample period, cycles
  reg [31:0] pkt_count; // Packets started
  wire [15:0] health; // Live health word
  reg [1:0] algo; // Encoded algorithm state
  reg [31:0] rd_val; // Read mux
  reg map_ok; // Address decodes

  // Read decode; unmapped addresses answer with an error
  always @* begin
    map_ok = 1'b1;
    case (paddr)
      `REG_MODEL: rd_val = {16'h0000, model_cfg};
      `REG_PERIOD: rd_val = period;
      `REG_STATUS: rd_val = {14'h0000, algo, health};
      `REG_COUNT: rd_val = pkt_count;
      default: begin
        rd_val = 32'h0;
        map_ok = 1'b0;
      end
    endcase
  end

  // APB slave: one wait state, write lands on the edge pready is seen
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
      model_cfg <= `MODEL_RST;
      period <= PERIOD_CYCLES[31:0];
    end else begin
      pready <= psel & penable & ~pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0 : rd_val;
        pslverr <= ~map_ok;
      end else begin
        pslverr <= 1'b0;
      end
      // Write completes
      if (psel && penable && pready && pwrite) begin
        if (paddr == `REG_MODEL) begin
          model_cfg <= pwdata[15:0];
        end
        if (paddr == `REG_PERIOD) begin
          period <= pwdata;
        end
      end
    end
  end

  // Sample-period timer; a new period value applies only at a boundary
  reg [31:0] rate_cnt; // Cycles into the period
  reg [31:0] cur_period; // Period in force
  reg pend; // A packet is owed
  wire tick; // Period boundary
  wire start; // Packet begins
  reg [1:0] pst; // Packet state

  assign tick = ({1'b0, rate_cnt} + 33'h1) >= {1'b0, cur_period};
  assign start = (pst == P_IDLE) && pend;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      rate_cnt <= 32'h0;
      cur_period <= PERIOD_CYCLES[31:0];
      pend <= 1'b0;
    end else begin
      if (tick) begin
        rate_cnt <= 32'h0;
        cur_period <= period;
      end else begin
        rate_cnt <= rate_cnt + 32'h1;
      end
      // Set wins; a tick while still owed is merged, so at most one per period
      if (tick) begin
        pend <= 1'b1;
      end else if (start) begin
        pend <= 1'b0;
      end
    end
  end

  // Algorithm state machine
  reg [2:0] ast; // Current state
  reg [35:0] init_cnt; // Consecutive level cycles

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ast <= A_NRDY;
      init_cnt <= 36'h0;
    end else begin
      case (ast)
        A_NRDY: begin
          init_cnt <= 36'h0;
          if (seen_sample && !over_range) begin
            ast <= A_INIT;
          end
        end
        A_INIT: begin
          if (over_range) begin
            ast <= A_NRDY;
          end else if (!level_ok) begin
            init_cnt <= 36'h0; // Level time must be unbroken
          end else if (init_cnt >= INIT_CYCLES - 36'h1) begin
            ast <= A_FULL;
          end else begin
            init_cnt <= init_cnt + 36'h1;
          end
        end
        A_FULL: begin
          if (over_range) begin
            ast <= A_NRDY;
          end
        end
        default: ast <= A_NRDY;
      endcase
    end
  end

  // State to health code
  always @* begin
    case (ast)
      A_INIT: algo = `ALG_INIT;
      A_FULL: algo = gyro_only ? `ALG_GYRO_ONLY : `ALG_FULL;
      default: algo = `ALG_NOT_READY;
    endcase
  end

  // Soft failure persistence and serial error flag
  reg [11:0] soft_cnt; // Packets with soft failure in a row
  reg hard_fail; // Latched until reset
  reg comm_err; // Serial error since last packet

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      soft_cnt <= 12'h000;
      hard_fail <= 1'b0;
      comm_err <= 1'b0;
    end else begin
      if (start) begin
        if (!soft_fail) begin
          soft_cnt <= 12'h000;
        end else if (soft_cnt >= `SOFT_LIMIT) begin
          hard_fail <= 1'b1;
        end else begin
          soft_cnt <= soft_cnt + 12'h001;
        end
      end
      // Error arriving as the packet starts is kept for the next one
      if (rx_err) begin
        comm_err <= 1'b1;
      end else if (start) begin
        comm_err <= 1'b0;
      end
    end
  end

  // Health word assembly
  reg [15:0] hw; // Working copy

  always @* begin
    hw = 16'h0000;
    hw[`HB_HARD] = hard_fail;
    hw[`HB_SOFT] = soft_fail | hard_fail;
    hw[`HB_NRDY] = (ast == A_NRDY) | cal_s2;
    hw[`HB_COMM] = comm_err;
    hw[`HB_TURN] = turn_det;
    hw[`HB_ALG_HI] = algo[1];
    hw[`HB_ALG_LO] = algo[0];
    hw[`HB_MAGCAL] = cal_s2;
  end

  assign health = hw;

  // Packet contents frozen at start so fresh samples cannot tear a packet
  reg [143:0] frm_words; // Measurement words
  reg [15:0] frm_model; // Model number
  reg [15:0] frm_health; // Health word
  wire [15:0] csum; // Checksum through current byte
  wire [207:0] frame; // Whole packet, byte 0 on top
  reg [4:0] idx; // Index of byte in tx_data
  wire [4:0] sel_idx; // Index of byte to load next
  wire [4:0] rix; // Byte position from the bottom
  wire accept; // Serialiser took a byte
  wire sum_en; // Byte counts toward checksum

  // Header, words MSB first, then model, health, checksum
  assign frame = {`HDR_FIRST, `HDR_SECOND, frm_words, frm_model, frm_health, csum};
  assign sel_idx = start ? 5'd0 : idx + 5'd1;
  assign rix = `PKT_LAST_BYTE - sel_idx;
  assign accept = tx_valid & tx_ready;
  assign sum_en = accept && (idx >= `CSUM_FIRST_BYTE) && (idx <= `CSUM_LAST_BYTE);

  // Checksum over content bytes as they leave
  frame_checksum u_csum (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clr(start),
    .add_en(sum_en),
    .byte_in(tx_data),
    .sum_next(csum)
  );

  // Packet sender: bytes go out back to back with no gaps of foreign data
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pst <= P_IDLE;
      idx <= 5'd0;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      frm_words <= 144'h0;
      frm_model <= `MODEL_RST;
      frm_health <= 16'h0000;
      pkt_count <= 32'h0;
    end else begin
      case (pst)
        P_IDLE: begin
          if (start) begin
            // Calibration output is zeroed and flagged as not valid
            frm_words <= cal_s2 ? 144'h0 : snap;
            frm_model <= model_cfg;
            frm_health <= health;
            pkt_count <= pkt_count + 32'h1;
            idx <= sel_idx;
            tx_data <= frame[{rix, 3'b000} +: 8];
            tx_valid <= 1'b1;
            pst <= P_SEND;
          end
        end
        P_SEND: begin
          if (accept) begin
            if (idx == `PKT_LAST_BYTE) begin
              tx_valid <= 1'b0;
              pst <= P_IDLE;
            end else begin
              idx <= sel_idx;
              tx_data <= frame[{rix, 3'b000} +: 8];
            end
          end
        end
        default: begin
          pst <= P_IDLE;
          tx_valid <= 1'b0;
        end
      endcase
    end
  end

endmodule // attitude_packet_framer
`default_nettype wire

// ### verilog/attitude_packet_framer_defines.vh
// Constants for the attitude packet framer: offsets, fields, reset values, timing.
// Assumes inclusion by bare name from the framer design files.
`ifndef ATTITUDE_PACKET_FRAMER_DEFINES_VH
`define ATTITUDE_PACKET_FRAMER_DEFINES_VH

// Sync header bytes, first then second
`define HDR_FIRST 8'hAA
`define HDR_SECOND 8'h55

// Byte positions inside one packet
`define PKT_LAST_BYTE 5'd25
`define CSUM_FIRST_BYTE 5'd2
`define CSUM_LAST_BYTE 5'd23

// Checksum divisor, one bit wider than the sum word
`define CSUM_DIV 17'h0FFFF

// Clock rate and default output rate
`define CLK_HZ 36'd100000000
`define RATE_HZ 36'd100
`define PERIOD_CYC (`CLK_HZ / `RATE_HZ)

// Level time before full accuracy, in seconds, and in cycles
`define INIT_TIME_S 36'd90
`define INIT_CYC (`INIT_TIME_S * `CLK_HZ)

// Soft failure persistence limit, in packets
`define SOFT_LIMIT 12'd2100

// APB register byte offsets
`define REG_MODEL 8'h00
`define REG_PERIOD 8'h04
`define REG_STATUS 8'h08
`define REG_COUNT 8'h0C

// Register reset values
`define MODEL_RST 16'h0000

// Health word bit positions
`define HB_HARD 0
`define HB_SOFT 1
`define HB_NRDY 2
`define HB_COMM 4
`define HB_TURN 8
`define HB_ALG_LO 9
`define HB_ALG_HI 10
`define HB_MAGCAL 11

// Algorithm status codes for health bits 10:9
`define ALG_NOT_READY 2'b11
`define ALG_INIT 2'b10
`define ALG_GYRO_ONLY 2'b01
`define ALG_FULL 2'b00

`endif

// ### verilog/frame_checksum.v
// Running checksum of packet bytes, kept as a remainder modulo 0xFFFF.
// Assumes one clock, synchronous active-high reset, clear at packet start.
`timescale 1ns/1ns
`default_nettype none
`include "attitude_packet_framer_defines.vh"

module frame_checksum (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // Byte feed
  input wire clr,
  input wire add_en,
  input wire [7:0] byte_in,
  // Sum including the byte being added now
  output reg [15:0] sum_next
);

  reg [15:0] acc; // Remainder so far, always below 0xFFFF
  reg [16:0] raw; // Remainder plus new byte
  reg [16:0] wrapped; // Raw less the divisor, used once raw reaches it

  // Reducing each step keeps the sum exact without a wide accumulator
  always @* begin
    raw = {1'b0, acc} + {9'h000, byte_in};
    wrapped = raw - `CSUM_DIV;
    if (!add_en) begin
      sum_next = acc;
    end else if (raw >= `CSUM_DIV) begin
      sum_next = wrapped[15:0];
    end else begin
      sum_next = raw[15:0];
    end
  end

  // Accumulator register
  always @(posedge clk_sys) begin
    if (sys_rst || clr) begin
      acc <= 16'h0000;
    end else begin
      acc <= sum_next;
    end
  end

endmodule // frame_checksum
`default_nettype wire

// ### testbench/attitude_packet_framer_asserts.sv
// Checker for the framer byte stream: header, checksum, hold, spacing.
// Assumes a bind to the framer top; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module attitude_packet_framer_asserts #(
  parameter [35:0] PERIOD_CYCLES = 36'd100, // Cycles per packet
  parameter [35:0] INIT_CYCLES = 36'd50 // Level time, unused here
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Status pins
  input wire logic over_range,
  input wire logic cal_pin,
  // Byte stream
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire acc = tx_valid && tx_ready; // Byte taken
  logic [4:0] idx; // Byte position
  int gap; // Cycles since a packet began
  int sum; // Sum of bytes 2..23
  int calc; // Cycles in calibration
  int ovrc; // Cycles over range
  wire [15:0] csum = 16'(sum % 32'h0000FFFF); // Wanted checksum
  // Position, sum and hold counters; sum frozen from byte 24 on
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      idx <= 5'h00;
      gap <= 0;
      sum <= 0;
      calc <= 0;
      ovrc <= 0;
    end else begin
      gap <= $rose(tx_valid) ? 1 : gap + 1;
      calc <= cal_pin ? calc + 1 : 0;
      ovrc <= over_range ? ovrc + 1 : 0;
      if (acc) begin
        idx <= (idx == 5'h19) ? 5'h00 : idx + 5'h01;
        sum <= (idx < 5'h02) ? 0 : (idx < 5'h18) ? sum + int'(tx_data) : sum;
      end
    end
  end
  AST_HDR_FIRST: assert property (tx_valid && idx == 5'h00 |-> tx_data == 8'hAA)
    else $error("header first byte wrong");
  AST_HDR_SECOND: assert property (tx_valid && idx == 5'h01 |-> tx_data == 8'h55)
    else $error("header second byte wrong");
  AST_CSUM_HIGH: assert property (tx_valid && idx == 5'h18 |-> tx_data == csum[15:8])
    else $error("checksum high byte wrong");
  AST_CSUM_LOW: assert property (tx_valid && idx == 5'h19 |-> tx_data == csum[7:0])
    else $error("checksum low byte wrong");
  AST_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("byte changed before taken");
  AST_NO_GAP: assert property (acc && idx != 5'h19 |=> tx_valid)
    else $error("gap inside packet");
  AST_END: assert property (acc && idx == 5'h19 |=> !tx_valid)
    else $error("stream runs past last byte");
  AST_SPACING: assert property ($rose(tx_valid) |-> gap >= PERIOD_CYCLES)
    else $error("packets closer than one period");
  AST_CAL_ZERO: assert property (tx_valid && idx > 5'h01 && idx < 5'h14 && calc >= 200 |-> tx_data == 8'h00)
    else $error("measurement sent in calibration");
  AST_OVER: assert property (tx_valid && idx == 5'h16 && ovrc >= 200 |-> tx_data[2:1] == 2'b11)
    else $error("over range not reported");
  COV_PACKET: cover property (acc && idx == 5'h19);
  COV_STALL: cover property (tx_valid && !tx_ready);
  COV_CAL: cover property (tx_valid && calc >= 200);
endmodule // attitude_packet_framer_asserts
bind attitude_packet_framer attitude_packet_framer_asserts #(
  .PERIOD_CYCLES(PERIOD_CYCLES),
  .INIT_CYCLES(INIT_CYCLES)
) asserts_u (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .over_range(over_range), .cal_pin(cal_pin),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready)
);
`default_nettype wire

// ### testbench/serial_byte_sink.sv
// Receiving side of the byte stream: paces ready, keeps the last packet.
// Assumes the framer's valid/ready byte handshake on one clock.
`timescale 1ns/1ns
`default_nettype none
module serial_byte_sink (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Byte stream
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // Pacing and capture
  input wire logic slow,
  output logic [207:0] pkt_flat,
  output logic [15:0] pkt_cnt
);
  logic [4:0] pos; // Byte position
  logic [1:0] ph; // Stall phase
  // Ready always, or one cycle in three when slow
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ph <= 2'h0;
      tx_ready <= 1'b0;
      pos <= 5'h00;
      pkt_cnt <= 16'h0000;
    end else begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      tx_ready <= !slow || ph == 2'h1;
      // Bytes shift in, first byte ends on top
      if (tx_valid && tx_ready) begin
        pkt_flat <= {pkt_flat[199:0], tx_data};
        pos <= (pos == 5'h19) ? 5'h00 : pos + 5'h01;
        if (pos == 5'h19) begin
          pkt_cnt <= pkt_cnt + 16'h0001;
        end
      end
    end
  end
endmodule // serial_byte_sink
`default_nettype wire

// ### testbench/attitude_packet_framer_tb.sv
// Self-checking bench: APB accesses and whole-packet compares.
// Assumes the framer top, the byte sink and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module attitude_packet_framer_tb;
  localparam [143:0] M1 = 144'h8001_7FFF_FFFF_0102_F00D_1234_C000_0080_FE01; // Signed mix
  localparam [143:0] M2 = 144'h0001_FFFE_7F00_8000_00FF_ABCD_4321_FFF0_0F0F; // Second set
  logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, meas_valid, slow;
  logic over_range, level_ok, gyro_only, soft_fail, turn_det, rx_err, cal_pin, rx_pin;
  logic [7:0] paddr, tx_data;
  logic [31:0] pwdata, prdata;
  logic [143:0] meas_words;
  logic tx_valid, tx_ready;
  logic [207:0] pkt_flat;
  logic [15:0] pkt_cnt, gap, model; // Gap between packets, expected model
  int err_total, n_compared;
  attitude_packet_framer #(.PERIOD_CYCLES(36'd100), .INIT_CYCLES(36'd50)) dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_valid(meas_valid), .meas_words(meas_words), .over_range(over_range), .level_ok(level_ok),
    .gyro_only(gyro_only), .soft_fail(soft_fail), .turn_det(turn_det), .rx_err(rx_err),
    .cal_pin(cal_pin), .rx_pin(rx_pin), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  serial_byte_sink sink_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow), .pkt_flat(pkt_flat), .pkt_cnt(pkt_cnt));
  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Compare and count
  task automatic note(input logic [207:0] got, input logic [207:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Checksum over bytes 2..23, wide sum then modulo
  function automatic logic [15:0] csum(input logic [175:0] b);
    logic [31:0] s;
    s = 0;
    for (int i = 0; i < 22; i++) s += 32'(b[175-8*i -: 8]);
    return 16'(s % 32'h0000FFFF);
  endfunction
  // APB transfer; compares {pslverr, prdata} when pready is seen
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] exp);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) err_total++;
    note(208'({pslverr, prdata}), 208'(exp));
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle so the next setup never reassigns psel in this time step
    @(posedge clk_sys);
  endtask
  // Wait for the next finished packet; serial input keeps wiggling
  task automatic next_pkt;
    logic [15:0] c0;
    c0 = pkt_cnt;
    gap = 16'h0000;
    while (pkt_cnt === c0 && gap < 16'd2000) begin
      @(posedge clk_sys);
      rx_pin <= ~rx_pin;
      gap++;
    end
    if (gap >= 16'd2000) err_total++;
  endtask
  // Skip some packets, then compare a whole one
  task automatic chk(input int skip, input logic [143:0] m, input logic [15:0] hw);
    repeat (skip + 1) next_pkt();
    note(pkt_flat, {16'hAA55, m, model, hw, csum({m, model, hw})});
  endtask
  // One sample capture
  task automatic pulse(input logic [143:0] m);
    meas_words <= m;
    meas_valid <= 1'b1;
    @(posedge clk_sys);
    meas_valid <= 1'b0;
  endtask
  // Verdict and end of run
  task automatic summarize;
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    summarize();
  end
  // Main sequence
  initial begin
    {sys_rst, psel, penable, pwrite, meas_valid, slow, over_range, level_ok} = 8'h80;
    {gyro_only, soft_fail, turn_det, rx_err, cal_pin, rx_pin} = 6'h00;
    {paddr, pwdata, meas_words, model} = '0;
    err_total = 0;
    n_compared = 0;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    pulse(M1);
    chk(0, M1, 16'h0400);
    acc(1'b0, 8'h04, 32'h0, 33'h0_00000064);
    acc(1'b1, 8'h00, 32'h0000A5C3, 33'h0);
    model = 16'hA5C3;
    acc(1'b0, 8'h00, 32'h0, 33'h0_0000A5C3);
    acc(1'b1, 8'h08, 32'hFFFFFFFF, 33'h0);
    acc(1'b0, 8'h08, 32'h0, 33'h0_00020400);
    acc(1'b0, 8'h10, 32'h0, 33'h1_00000000);
    acc(1'b0, 8'h0C, 32'h0, 33'h0_00000001);
    chk(1, M1, 16'h0400);
    rx_err <= 1'b1;
    turn_det <= 1'b1;
    chk(1, M1, 16'h0510);
    rx_err <= 1'b0;
    turn_det <= 1'b0;
    over_range <= 1'b1;
    chk(2, M1, 16'h0604);
    over_range <= 1'b0;
    level_ok <= 1'b1;
    pulse(M2);
    chk(1, M2, 16'h0000);
    gyro_only <= 1'b1;
    soft_fail <= 1'b1;
    slow <= 1'b1;
    chk(1, M2, 16'h0202);
    {gyro_only, soft_fail, slow} <= 3'h0;
    cal_pin <= 1'b1;
    chk(2, 144'h0, 16'h0804);
    cal_pin <= 1'b0;
    acc(1'b1, 8'h04, 32'd150, 33'h0);
    repeat (3) next_pkt();
    note(208'(gap), 208'(16'd150));
    summarize();
  end
endmodule // attitude_packet_framer_tb
`default_nettype wire
